// *** rtl/page_read_consts.vh ***
`ifndef PAGE_READ_CONSTS_VH
`define PAGE_READ_CONSTS_VH

// Register byte addresses on the APB side.
`define ADDR_CTRL 12'h000
`define ADDR_CMD 12'h004
`define ADDR_PAGE 12'h008
`define ADDR_DATA 12'h00C
`define ADDR_STATUS 12'h010
`define ADDR_MASK 12'h014

// Control register fields.
`define CTRL_DMA_MODE 0
`define CTRL_START 1

// Status register fields (sticky, write one to clear).
`define ST_WORD 0
`define ST_DONE 1
`define ST_BADCMD 2
`define ST_W 3

// Page geometry: 528 bytes, 132 words.
`define PAGE_WORDS 8'h84
`define LAST_WORD 8'h83
`define LAST_LANE 2'h3

// Last of the three page address bytes.
`define ADDR_LAST 2'h2
// Cycles to wait after the address before the ready line is trusted.
`define BUSY_SETTLE 4'h8

// The only read command the card path accepts.
`define CMD_READ 8'h00
`define CMD_FIELD_LO 8
`define CMD_FIELD_HI 15

`endif

// *** rtl/page_read_path.v ***
`timescale 1ns/1ps
// Operation
// [R1] A 32-bit read-only register holds four consecutive card bytes.
// [R2] Incoming bytes gather in a four-byte buffer forming one word.
// [R3] First byte lands in the low lane, fourth in the high lane.
// [R4] Processor or DMA must read the data register for each word.
// [R5] One transaction reads the whole page; 132 reads drain it.
// [R6] A page read moves all 528 bytes including the spare area.
// [R7] Software writes command word xxxx00yy; upper half may carry an id.
// [R8] Only command code 00h is valid; 01h and 50h are refused.
// [R9] Software loads the page address before the read starts.
// [R10] The card cycle issues the command then the page address.
// [R11] Each assembled word raises an interrupt or a DMA request.
// [R12] The word stays put until read; only then are new bytes fetched.
`include "page_read_consts.vh"

module page_read_path (
  input wire clk, // 100 MHz clock
  input wire nrst, // asynchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error on unmapped address
  output reg irq, // level interrupt
  output reg dma_req, // DMA request level, one word ready
  output reg card_cle, // card command latch enable
  output reg card_ale, // card address latch enable
  output reg card_we_n, // card write strobe, active low
  output reg card_re_n, // card read strobe, active low
  output reg [7:0] card_io_out, // card bus drive value
  output reg card_io_oe, // card bus driven by us
  input wire [7:0] card_io_in, // card bus sampled value
  input wire card_ready // card ready, high when not busy
);

  // One-hot sequencer states; SETTLE covers the busy line's rise time.
  localparam S_IDLE = 9'h001;
  localparam S_CMD = 9'h002;
  localparam S_ADDR = 9'h004;
  localparam S_SETTLE = 9'h008;
  localparam S_WAIT = 9'h010;
  localparam S_RDLO = 9'h020;
  localparam S_RDHI = 9'h040;
  localparam S_SAMP = 9'h080;
  localparam S_HOLD = 9'h100;

  //////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  reg rst_m;
  reg rst_s;
  reg [8:0] pin_m;
  reg [8:0] pin_s;
  // Bit 8 carries the ready line, bits 7:0 the card bus.

  // The reset goes out asynchronously and comes back in through two flops.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_m <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_s <= rst_m;
    end
  end

  // Card bus and busy line arrive from outside, so two flops first.
  // Only the second stage is read; the first may still be resolving.
  always @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      pin_m <= 9'h000;
      pin_s <= 9'h000;
    end else begin
      pin_m <= {card_ready, card_io_in};
      pin_s <= pin_m;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register file.
  // Map: control, command word, page address, data word, status, mask.
  // Status bits are sticky and cleared by writing ones; a set wins over a
  // clear in the same cycle so no event slips between read and clear.

  // Software-visible registers, then sequencer state.
  reg dma_mode;
  reg [31:0] media_command_word;
  reg [31:0] media_page_address;
  reg [31:0] page_read_data_word;
  reg [`ST_W-1:0] status;
  reg [`ST_W-1:0] mask;
  reg [8:0] state;
  reg [3:0] settle;
  reg [1:0] addr_idx;
  reg [1:0] lane;
  reg [7:0] words;
  reg [23:0] assemble;
  reg word_full;
  wire setup = psel && !penable;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire data_rd = acc && !pwrite && paddr == `ADDR_DATA;
  // Strobes count only in the cycle that completes the transfer, so a
  // master that stretches its access phase cannot start or finish twice.
  wire start = wr && pready && paddr == `ADDR_CTRL && pwdata[`CTRL_START];
  wire cmd_ok = media_command_word[`CMD_FIELD_HI:`CMD_FIELD_LO] == `CMD_READ;
  // Word event marks the edge at which the fourth byte lands.
  wire word_evt = state == S_SAMP && lane == `LAST_LANE; // [R11]
  wire done_evt = data_rd && pready && word_full && words == `PAGE_WORDS; // [R5]
  wire bad_evt = start && state == S_IDLE && !cmd_ok;
  wire [`ST_W-1:0] events = {bad_evt, done_evt, word_evt};
  wire mapped = paddr == `ADDR_CTRL || paddr == `ADDR_CMD || paddr == `ADDR_PAGE ||
    paddr == `ADDR_DATA || paddr == `ADDR_STATUS || paddr == `ADDR_MASK;
  reg [31:0] next_prdata;

  // Read mux; data register is read-only and writes to it are dropped.
  // Unmapped offsets read as zero and raise the error flag with ready.
  always @* begin
    case (paddr)
      `ADDR_CTRL: next_prdata = {31'h00000000, dma_mode};
      `ADDR_CMD: next_prdata = media_command_word;
      `ADDR_PAGE: next_prdata = media_page_address;
      `ADDR_DATA: next_prdata = page_read_data_word; // [R1]
      `ADDR_STATUS: next_prdata = {29'h00000000, status};
      `ADDR_MASK: next_prdata = {29'h00000000, mask};
      default: next_prdata = 32'h00000000;
    endcase
  end

  // No wait state: ready rises in the first access cycle after setup.
  // Registering ready off the setup cycle costs no extra cycle and keeps every output a flop.
  always @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      dma_mode <= 1'b0;
      media_command_word <= 32'h00000000;
      media_page_address <= 32'h00000000;
      mask <= 3'h0;
      status <= 3'h0;
      irq <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup && !pwrite ? next_prdata : 32'h00000000;
      if (wr && pready && paddr == `ADDR_CTRL)
        dma_mode <= pwdata[`CTRL_DMA_MODE];
      if (wr && pready && paddr == `ADDR_CMD)
        media_command_word <= pwdata; // [R7]
      if (wr && pready && paddr == `ADDR_PAGE)
        media_page_address <= pwdata; // [R9]
      if (wr && pready && paddr == `ADDR_MASK)
        mask <= pwdata[`ST_W-1:0];
      // Set beats clear so an event in the clearing cycle survives.
      if (wr && pready && paddr == `ADDR_STATUS)
        status <= (status & ~pwdata[`ST_W-1:0]) | events;
      else
        status <= status | events;
      // The level interrupt trails the status bits by one cycle.
      irq <= |(status & mask);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Card sequencer.

  // Command, three address bytes, then 528 byte reads packed into words.
  // A start while a page is in flight is ignored; software sees the page
  // through to its last word before it may ask for another.
  always @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      state <= S_IDLE;
      card_cle <= 1'b0;
      card_ale <= 1'b0;
      card_we_n <= 1'b1;
      card_re_n <= 1'b1;
      card_io_out <= 8'h00;
      card_io_oe <= 1'b0;
      addr_idx <= 2'h0;
      settle <= 4'h0;
      lane <= 2'h0;
      words <= 8'h00;
      assemble <= 24'h000000;
      page_read_data_word <= 32'h00000000;
      word_full <= 1'b0;
      dma_req <= 1'b0;
    end else begin
      // Word consumed by a data read; this unblocks the next fetch.
      // Only a completed read counts, so a stretched access drains one word.
      if (data_rd && pready && word_full) begin
        word_full <= 1'b0; // [R4]
        dma_req <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          // Bad codes (01h, 50h, anything but 00h) never reach the card.
          if (start && cmd_ok) begin // [R8]
            state <= S_CMD;
            card_cle <= 1'b1;
            card_io_oe <= 1'b1;
            card_io_out <= `CMD_READ; // [R10]
            card_we_n <= 1'b0;
            words <= 8'h00;
            lane <= 2'h0;
            word_full <= 1'b0;
            dma_req <= 1'b0;
          end
        end
        S_CMD: begin
          // Rising write strobe latches the command, then address bytes.
          // Strobe pairs: low one cycle, high one cycle, bus steady across both.
          if (!card_we_n) begin
            card_we_n <= 1'b1;
          end else begin
            card_cle <= 1'b0;
            card_ale <= 1'b1;
            addr_idx <= 2'h0;
            card_io_out <= media_page_address[7:0]; // [R10]
            card_we_n <= 1'b0;
            state <= S_ADDR;
          end
        end
        S_ADDR: begin
          if (!card_we_n) begin
            card_we_n <= 1'b1;
          end else if (addr_idx == `ADDR_LAST) begin
            // The card needs a moment to pull its busy line, and our copy of it
            // lags by two flops; looking at it now would read a stale ready.
            card_ale <= 1'b0;
            card_io_oe <= 1'b0;
            settle <= `BUSY_SETTLE;
            state <= S_SETTLE;
          end else begin
            // Page address goes out low byte first, one strobe pair per byte.
            addr_idx <= addr_idx + 2'h1;
            card_io_out <= addr_idx == 2'h0 ? media_page_address[15:8] :
              media_page_address[23:16];
            card_we_n <= 1'b0;
          end
        end
        S_SETTLE: begin
          // Count down the settling time, then trust the ready line.
          if (settle == 4'h0)
            state <= S_WAIT;
          else
            settle <= settle - 4'h1;
        end
        S_WAIT: begin
          // The synchronised ready line lags the pin by two cycles.
          // An unread word blocks the next strobe, so no byte is ever lost.
          if (pin_s[8] && !word_full) begin // [R12]
            card_re_n <= 1'b0;
            state <= S_RDLO;
          end
        end
        S_RDLO: begin
          // One cycle low is the shortest strobe that still leaves the card
          // time to drive the bus before we look at it.
          card_re_n <= 1'b1;
          state <= S_RDHI;
        end
        S_RDHI: begin
          // The byte is in the first flop now; wait one more edge for the second.
          state <= S_SAMP;
        end
        S_SAMP: begin
          // Byte sampled through the synchroniser; lane 0 is the first byte.
          lane <= lane + 2'h1;
          if (lane == `LAST_LANE) begin
            // Fourth byte goes straight to the top lane, skipping the buffer.
            page_read_data_word <= {pin_s[7:0], assemble}; // [R2] [R3]
            word_full <= 1'b1;
            dma_req <= dma_mode; // [R11]
            words <= words + 8'h01;
            state <= words == `LAST_WORD ? S_HOLD : S_WAIT; // [R5] [R6]
          end else begin
            case (lane)
              2'h0: assemble[7:0] <= pin_s[7:0];
              2'h1: assemble[15:8] <= pin_s[7:0];
              default: assemble[23:16] <= pin_s[7:0];
            endcase
            state <= S_WAIT;
          end
        end
        S_HOLD: begin
          // Last word waits for its read before another page may start.
          // Going idle early would let a new start clear an unread word.
          if (!word_full)
            state <= S_IDLE; // [R12]
        end
        // A stray code falls back to idle rather than lock up.
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

// *** dv/page_read_assertions.sv ***
`timescale 1ns/1ps
// Port-level watch on the page read path.
module page_read_checker (
  input wire clk, // clock
  input wire nrst, // reset
  input wire psel, // select
  input wire penable, // enable
  input wire pwrite, // direction
  input wire [11:0] paddr, // address
  input wire pready, // ready
  input wire dma_req, // dma
  input wire card_cle, // cmd latch
  input wire card_ale, // addr latch
  input wire card_we_n, // write strobe
  input wire card_re_n, // read strobe
  input wire [7:0] card_io_out // card bus
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // A read of the data word on this edge hands the word over.
  wire take = psel && penable && pready && !pwrite && paddr == 12'h00C;
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("ready late");
  a_cmd_zero: assert property ($rose(card_cle) |-> card_io_out == 8'h00 && !card_we_n)
    else $error("bad command");
  a_addr_follow: assert property ($rose(card_ale) |-> $past(card_cle, 2))
    else $error("address early");
  a_we_short: assert property ($fell(card_we_n) |=> card_we_n)
    else $error("strobe long");
  a_read_clear: assert property ($fell(card_re_n) |-> !card_ale && !card_cle)
    else $error("read overlaps");
  a_word_hold: assert property (dma_req && !take |=> dma_req)
    else $error("word lost");
  a_word_done: assert property (dma_req && take |=> !dma_req)
    else $error("request stuck");
  a_no_refetch: assert property (dma_req |-> card_re_n)
    else $error("fetch early");
  // Reaching these shows DMA mode, the card address cycle and a data read were exercised.
  c_dma: cover property ($rose(dma_req));
  c_addr: cover property ($rose(card_ale));
  c_take: cover property (take);
endmodule
////////////////////////////////////////
bind page_read_path page_read_checker chk (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .dma_req(dma_req),
  .card_cle(card_cle), .card_ale(card_ale), .card_we_n(card_we_n), .card_re_n(card_re_n),
  .card_io_out(card_io_out));

// *** dv/card_model.sv ***
`timescale 1ns/1ps
// Card stand-in: latches command and address, then serves page bytes.
module card_model (
  input wire clk, // clock
  input wire card_cle, // cmd latch
  input wire card_ale, // addr latch
  input wire card_we_n, // write strobe
  input wire card_re_n, // read strobe
  input wire [7:0] card_io_out, // bus in
  output wire [7:0] card_io_in, // bus out
  output wire card_ready, // not busy
  output reg [7:0] cmd = 8'hFF, // last command
  output reg [23:0] addr = 24'h0, // last address
  output reg [15:0] nbytes = 16'h0 // bytes served
);
  reg we_d = 1'b1;
  reg re_d = 1'b1;
  reg ale_d = 1'b0;
  reg [3:0] hold = 4'h0;
  reg [3:0] busy = 4'h0;
  wire [7:0] cur = nbytes[7:0] ^ 8'hC3;
  assign card_ready = busy == 4'h0;
  // The byte shows as soon as the strobe falls and stands three more edges;
  // an idle bus shows the inverse, so a late sample is caught.
  assign card_io_in = (!card_re_n || hold != 4'h0) ? cur : ~cur;
  always @(posedge clk) begin
    we_d <= card_we_n;
    re_d <= card_re_n;
    ale_d <= card_ale;
    if (we_d && !card_we_n && card_cle) begin
      cmd <= card_io_out;
      nbytes <= 16'h0;
    end
    if (we_d && !card_we_n && card_ale)
      addr <= {card_io_out, addr[23:8]};
    busy <= (ale_d && !card_ale) ? 4'hC : busy - {3'h0, busy != 4'h0};
    if (re_d && !card_re_n)
      hold <= 4'h3;
    else if (hold != 4'h0)
      hold <= hold - 4'h1;
    if (hold == 4'h1)
      nbytes <= nbytes + 16'h1;
  end
endmodule

// *** dv/media_card_page_read_path_test.sv ***
`timescale 1ns/1ps
module media_card_page_read_path_test;
  reg clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rdata, ew;
  wire [31:0] prdata;
  wire pready, pslverr, irq, dma_req, cle, ale, we_n, re_n, io_oe, ready;
  wire [7:0] io_out, io_card, cmd;
  wire [23:0] addr;
  wire [15:0] nbytes;
  integer err_count = 0, check_count = 0, m, w, k;
  page_read_path uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .dma_req(dma_req), .card_cle(cle), .card_ale(ale), .card_we_n(we_n),
    .card_re_n(re_n), .card_io_out(io_out), .card_io_oe(io_oe),
    .card_io_in(io_oe ? io_out : io_card), .card_ready(ready));
  card_model card (.clk(clk), .card_cle(cle), .card_ale(ale), .card_we_n(we_n),
    .card_re_n(re_n), .card_io_out(io_out), .card_io_in(io_card), .card_ready(ready),
    .cmd(cmd), .addr(addr), .nbytes(nbytes));
  // Free-running 100 MHz clock.
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
    end
  endtask
  // The request stands until ready is sampled high; an idle cycle follows.
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task give_verdict;
    begin
      if (err_count == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // A hang ends the run as a failure.
  initial begin
    repeat (40000) @(posedge clk);
    err_count = err_count + 1;
    give_verdict;
  end
  ////////////////////////////////////////
  // Two full pages, interrupt mode then DMA mode; refused codes; an unmapped read.
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1, 12'h014, 32'h7);
    apb(1, 12'h008, 32'h563412);
    for (m = 0; m < 2; m = m + 1) begin
      apb(1, 12'h004, 32'hBEEF00A5);
      apb(1, 12'h000, 32'h2 | m);
      for (w = 0; w < 132; w = w + 1) begin
        repeat (2) @(posedge clk);
        while ((m ? dma_req : irq) !== 1'b1)
          @(posedge clk);
        if (w == 0) begin
          repeat (20) @(posedge clk);
          chk({16'h0, nbytes}, 32'h4);
        end
        apb(0, 12'h00C, 32'h0);
        for (k = 0; k < 4; k = k + 1)
          ew[8*k +: 8] = 8'(4 * w + k) ^ 8'hC3;
        chk(rdata, ew);
        apb(1, 12'h010, 32'h1);
      end
      chk({cmd, addr}, 32'h00563412);
      chk({16'h0, nbytes}, 32'd528);
      apb(0, 12'h010, 32'h0);
      chk(rdata & 32'h2, 32'h2);
      apb(1, 12'h010, 32'h7);
    end
    // The first refused code has its status bit masked, the second not.
    for (m = 0; m < 2; m = m + 1) begin
      apb(1, 12'h014, 32'h3 | (m << 2));
      apb(1, 12'h004, m ? 32'h5000 : 32'h0100);
      apb(1, 12'h000, 32'h2);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, m);
      apb(0, 12'h010, 32'h0);
      chk(rdata, 32'h4);
      apb(1, 12'h010, 32'h4);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    chk({16'h0, nbytes}, 32'd528);
    apb(1, 12'h00C, 32'hFFFFFFFF);
    apb(0, 12'h00C, 32'h0);
    chk(rdata, 32'hCCCDCECF);
    apb(0, 12'h020, 32'h0);
    chk(rdata, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    give_verdict;
  end
endmodule
